/* sar_rx.v */
`timescale 1ns/100ps
`include "sar_map.vh"
module sar_rx #(
    parameter RX_CH    = 1,
    parameter MAX_BITS = 9
) (
    // Clock, reset and unit clock gate.
    input  wire        core_clk,
    input  wire        rst,
    input  wire        peripheral_clock_gate,
    // Avalon-MM slave.
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Serial line and interrupts.
    input  wire        serial_in_pin,
    output reg         receive_end_irq,
    output reg         receive_error_irq
);

    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_START  = 3'h1;
    localparam [2:0] ST_DATA   = 3'h2;
    localparam [2:0] ST_PARITY = 3'h3;
    localparam [2:0] ST_STOP   = 3'h4;

    // Gating the peripheral clock holds the unit in reset.
    wire srst = rst | ~peripheral_clock_gate;

    reg                clock_source_select;
    reg                mode_inv;
    reg  [15:0]        paired_channel_mode_reg;
    reg                receive_enable_bit;
    reg  [1:0]         parity_mode;
    reg                lsb_first;
    reg  [3:0]         len_code;
    reg  [6:0]         divider;
    reg  [3:0]         prescaler_low_field;
    reg  [3:0]         prescaler_high_field;
    reg                chan_enable;
    reg  [15:0]        output_level_reg;
    reg  [15:0]        output_enable_reg;
    reg  [MAX_BITS-1:0] rx_char;
    reg                buf_full;
    reg                overrun_error_flag;
    reg                parity_error_flag;
    reg                framing_error_flag;
    reg  [2:0]         state;
    reg  [8:0]         cnt;
    reg  [3:0]         bitn;
    reg  [MAX_BITS-1:0] shreg;
    reg                par_acc;
    reg                pe_hold;
    reg                armed;
    reg                done_p;
    reg                fe_p;
    reg                pe_p;
    reg  [31:0]        next_readdata;

    wire               mck_en;
    wire               pin_level;
    wire               line = pin_level ^ mode_inv;
    wire               run = chan_enable & receive_enable_bit;
    wire               access = avs_waitrequest & (avs_read | avs_write);
    wire               wr = ~avs_waitrequest & avs_write; // Lands at the completing edge.
    wire               rd = access & avs_read & ~avs_write;
    wire [15:0]        wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [15:0]        wdat = avs_writedata[15:0] & wmask;
    wire               start_hit = wr & (avs_address == `SAR_OFS_START) & wdat[RX_CH];
    wire               stop_hit = wr & (avs_address == `SAR_OFS_STOP) & wdat[RX_CH];
    wire               clr_hit = wr & (avs_address == `SAR_OFS_FLAG_CLR);
    wire               data_rd = rd & (avs_address == `SAR_OFS_DATA);
    wire               transfer_in_progress = (state != ST_IDLE);
    wire [8:0]         half_bit = {2'h0, divider} + 9'h001;
    wire [8:0]         full_bit = {1'b0, half_bit[7:0]} << 1;
    wire [8:0]         cnt_next = cnt + 9'h001;
    wire [3:0]         len_m1;
    wire [MAX_BITS-1:0] rev;
    wire [MAX_BITS-1:0] char_word;

    // Only 7, 8 and 9 bit lengths are kept; any other code reads as 8 bits.
    assign len_m1 = (len_code == `SAR_LEN_7 || len_code == `SAR_LEN_9) ? len_code
                                                                       : `SAR_LEN_8;

    // LSB-first frames arrive reversed in the shift register.
    genvar i;
    generate
        for (i = 0; i < MAX_BITS; i = i + 1) begin : g_rev
            assign rev[i] = (i <= len_m1) ? shreg[len_m1 - i] : 1'b0;
        end
    endgenerate

    // MSB-first character masked to the length; the character sits from bit 0.
    assign char_word = lsb_first ? rev
                                 : (shreg & ~({MAX_BITS{1'b1}} << (len_m1 + 4'h1)));

    sar_prescaler #(
        .MAX_POW (15)
    ) sar_prescaler_inst (
        .core_clk (core_clk),
        .srst     (srst),
        .sel_high (clock_source_select),
        .prs_low  (prescaler_low_field),
        .prs_high (prescaler_high_field),
        .mck_en   (mck_en)
    );

    sar_pin_sync sar_pin_sync_inst (
        .core_clk (core_clk),
        .srst     (srst),
        .pin      (serial_in_pin),
        .level    (pin_level)
    );

    // Bus handshake: each request is answered one cycle after it is seen.
    always @(posedge core_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            if (access) begin
                avs_waitrequest <= 1'b0;
            end else begin
                avs_waitrequest <= 1'b1;
            end
            if (rd) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    // Read multiplexer; unmapped and write-only offsets read as zero.
    always @* begin
        next_readdata = 32'h00000000;
        case (avs_address)
            `SAR_OFS_MODE: begin
                next_readdata[`SAR_MODE_CKS] = clock_source_select;
                next_readdata[`SAR_MODE_INV] = mode_inv;
            end
            `SAR_OFS_PAIR_MODE: next_readdata[15:0] = paired_channel_mode_reg;
            `SAR_OFS_CONTROL: begin
                next_readdata[`SAR_CTL_RXE] = receive_enable_bit;
                next_readdata[`SAR_CTL_PAR_HI:`SAR_CTL_PAR_LO] = parity_mode;
                next_readdata[`SAR_CTL_LSB] = lsb_first;
                next_readdata[`SAR_CTL_LEN_HI:`SAR_CTL_LEN_LO] = len_code;
            end
            `SAR_OFS_DATA: begin
                next_readdata[`SAR_DIV_HI:`SAR_DIV_LO] = divider;
                next_readdata[`SAR_CHR_HI:0] = rx_char;
            end
            `SAR_OFS_PRESCALE: begin
                next_readdata[`SAR_PRS_LO_HI:`SAR_PRS_LO_LO] = prescaler_low_field;
                next_readdata[`SAR_PRS_HI_HI:`SAR_PRS_HI_LO] = prescaler_high_field;
            end
            `SAR_OFS_STATUS: begin
                next_readdata[`SAR_ST_OVF]   = overrun_error_flag;
                next_readdata[`SAR_ST_PEF]   = parity_error_flag;
                next_readdata[`SAR_ST_FEF]   = framing_error_flag;
                next_readdata[`SAR_ST_BFULL] = buf_full;
                next_readdata[`SAR_ST_TIP]   = transfer_in_progress;
            end
            `SAR_OFS_ENABLE:    next_readdata[RX_CH] = chan_enable;
            `SAR_OFS_OUT_LEVEL: next_readdata[15:0] = output_level_reg;
            `SAR_OFS_OUT_EN:    next_readdata[15:0] = output_enable_reg;
            default:            next_readdata = 32'h00000000;
        endcase
    end

    // Configuration registers written by software, byte lanes honoured.
    always @(posedge core_clk) begin
        if (srst) begin
            clock_source_select     <= 1'b0;
            mode_inv                <= 1'b0;
            paired_channel_mode_reg <= `SAR_RST_HALF16;
            receive_enable_bit      <= 1'b0;
            parity_mode             <= `SAR_PAR_NONE;
            lsb_first               <= 1'b1;
            len_code                <= `SAR_LEN_8;
            divider                 <= `SAR_RST_DIV;
            prescaler_low_field     <= 4'h0;
            prescaler_high_field    <= 4'h0;
            output_level_reg        <= `SAR_RST_HALF16;
            output_enable_reg       <= `SAR_RST_HALF16;
        end else if (wr) begin
            case (avs_address)
                `SAR_OFS_MODE: if (avs_byteenable[0]) begin
                    clock_source_select <= avs_writedata[`SAR_MODE_CKS];
                    mode_inv            <= avs_writedata[`SAR_MODE_INV];
                end
                `SAR_OFS_PAIR_MODE: begin
                    paired_channel_mode_reg <= (paired_channel_mode_reg & ~wmask) | wdat;
                end
                `SAR_OFS_CONTROL: if (avs_byteenable[0]) begin
                    receive_enable_bit <= avs_writedata[`SAR_CTL_RXE];
                    parity_mode        <= avs_writedata[`SAR_CTL_PAR_HI:`SAR_CTL_PAR_LO];
                    lsb_first          <= avs_writedata[`SAR_CTL_LSB];
                    len_code           <= avs_writedata[`SAR_CTL_LEN_HI:`SAR_CTL_LEN_LO];
                end
                `SAR_OFS_DATA: if (avs_byteenable[1]) begin
                    divider <= avs_writedata[`SAR_DIV_HI:`SAR_DIV_LO];
                end
                `SAR_OFS_PRESCALE: if (avs_byteenable[0]) begin
                    prescaler_low_field  <= avs_writedata[`SAR_PRS_LO_HI:`SAR_PRS_LO_LO];
                    prescaler_high_field <= avs_writedata[`SAR_PRS_HI_HI:`SAR_PRS_HI_LO];
                end
                // Stored only; the receiver never looks at these two.
                `SAR_OFS_OUT_LEVEL: output_level_reg <= (output_level_reg & ~wmask) | wdat;
                `SAR_OFS_OUT_EN:    output_enable_reg <= (output_enable_reg & ~wmask) | wdat;
                default: begin
                end
            endcase
        end
    end

    // Channel enable: start sets it, stop clears it, stop wins if both.
    always @(posedge core_clk) begin
        if (srst) begin
            chan_enable <= 1'b0;
        end else if (stop_hit) begin
            chan_enable <= 1'b0;
        end else if (start_hit) begin
            chan_enable <= 1'b1;
        end
    end

    // Frame receiver paced by the operating clock enable.
    always @(posedge core_clk) begin
        if (srst || !run || stop_hit || start_hit) begin
            state   <= ST_IDLE;
            cnt     <= 9'h000;
            bitn    <= 4'h0;
            shreg   <= {MAX_BITS{1'b0}};
            par_acc <= 1'b0;
            pe_hold <= 1'b0;
            armed   <= 1'b0;
            done_p  <= 1'b0;
            fe_p    <= 1'b0;
            pe_p    <= 1'b0;
        end else begin
            done_p <= 1'b0;
            if (mck_en) begin
                case (state)
                    ST_IDLE: begin
                        // A falling edge needs the line seen high first.
                        if (line) begin
                            armed <= 1'b1;
                        end else if (armed) begin
                            armed   <= 1'b0;
                            state   <= ST_START;
                            cnt     <= 9'h000;
                            pe_hold <= 1'b0;
                            par_acc <= 1'b0;
                        end
                    end
                    ST_START: begin
                        // Re-check the start bit at its centre.
                        if (cnt_next >= half_bit) begin
                            cnt   <= 9'h000;
                            bitn  <= 4'h0;
                            state <= line ? ST_IDLE : ST_DATA;
                        end else begin
                            cnt <= cnt_next;
                        end
                    end
                    ST_DATA: begin
                        if (cnt_next >= full_bit) begin
                            cnt     <= 9'h000;
                            shreg   <= {shreg[MAX_BITS-2:0], line};
                            par_acc <= par_acc ^ line;
                            bitn    <= bitn + 4'h1;
                            if (bitn == len_m1) begin
                                state <= (parity_mode == `SAR_PAR_NONE) ? ST_STOP
                                                                        : ST_PARITY;
                            end
                        end else begin
                            cnt <= cnt_next;
                        end
                    end
                    ST_PARITY: begin
                        if (cnt_next >= full_bit) begin
                            cnt   <= 9'h000;
                            state <= ST_STOP;
                            case (parity_mode)
                                `SAR_PAR_ZERO: pe_hold <= line;
                                `SAR_PAR_EVEN: pe_hold <= par_acc ^ line;
                                `SAR_PAR_ODD:  pe_hold <= ~(par_acc ^ line);
                                default:       pe_hold <= 1'b0;
                            endcase
                        end else begin
                            cnt <= cnt_next;
                        end
                    end
                    ST_STOP: begin
                        if (cnt_next >= full_bit) begin
                            cnt    <= 9'h000;
                            state  <= ST_IDLE;
                            done_p <= 1'b1;
                            fe_p   <= ~line;
                            pe_p   <= pe_hold;
                        end else begin
                            cnt <= cnt_next;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // Flags and character buffer; a new event wins over a clear.
    always @(posedge core_clk) begin
        if (srst) begin
            rx_char            <= {MAX_BITS{1'b0}};
            buf_full           <= 1'b0;
            overrun_error_flag <= 1'b0;
            parity_error_flag  <= 1'b0;
            framing_error_flag <= 1'b0;
            receive_end_irq    <= 1'b0;
            receive_error_irq  <= 1'b0;
        end else begin
            if (done_p) begin
                rx_char <= char_word;
            end
            buf_full <= done_p | (buf_full & ~data_rd);
            overrun_error_flag <= (done_p & buf_full & ~data_rd) |
                                  (overrun_error_flag & ~(clr_hit & wdat[`SAR_ST_OVF]));
            parity_error_flag  <= (done_p & pe_p) |
                                  (parity_error_flag & ~(clr_hit & wdat[`SAR_ST_PEF]));
            framing_error_flag <= (done_p & fe_p) |
                                  (framing_error_flag & ~(clr_hit & wdat[`SAR_ST_FEF]));
            receive_end_irq    <= done_p;
            receive_error_irq  <= done_p & (fe_p | pe_p | (buf_full & ~data_rd));
        end
    end

endmodule // sar_rx

/* sar_map.vh */
`ifndef SAR_MAP_VH
`define SAR_MAP_VH

// Register byte offsets on the Avalon bus.
`define SAR_OFS_MODE      6'h00
`define SAR_OFS_PAIR_MODE 6'h04
`define SAR_OFS_CONTROL   6'h08
`define SAR_OFS_DATA      6'h0c
`define SAR_OFS_PRESCALE  6'h10
`define SAR_OFS_START     6'h14
`define SAR_OFS_STOP      6'h18
`define SAR_OFS_STATUS    6'h1c
`define SAR_OFS_FLAG_CLR  6'h20
`define SAR_OFS_ENABLE    6'h24
`define SAR_OFS_OUT_LEVEL 6'h28
`define SAR_OFS_OUT_EN    6'h2c

// Mode register fields.
`define SAR_MODE_CKS      0
`define SAR_MODE_INV      1

// Control register fields.
`define SAR_CTL_RXE       0
`define SAR_CTL_PAR_LO    1
`define SAR_CTL_PAR_HI    2
`define SAR_CTL_LSB       3
`define SAR_CTL_LEN_LO    4
`define SAR_CTL_LEN_HI    7

// Data register fields: divider in bits 15:9, character in 8:0.
`define SAR_DIV_LO        9
`define SAR_DIV_HI        15
`define SAR_CHR_HI        8

// Prescaler register fields.
`define SAR_PRS_LO_LO     0
`define SAR_PRS_LO_HI     3
`define SAR_PRS_HI_LO     4
`define SAR_PRS_HI_HI     7

// Status and flag-clear bit positions.
`define SAR_ST_OVF        0
`define SAR_ST_PEF        1
`define SAR_ST_FEF        2
`define SAR_ST_BFULL      5
`define SAR_ST_TIP        6

// Parity modes.
`define SAR_PAR_NONE      2'h0
`define SAR_PAR_ZERO      2'h1
`define SAR_PAR_EVEN      2'h2
`define SAR_PAR_ODD       2'h3

// Length codes (bits minus one) and reset values.
`define SAR_LEN_7         4'h6
`define SAR_LEN_8         4'h7
`define SAR_LEN_9         4'h8
`define SAR_RST_DIV       7'h02
`define SAR_RST_HALF16    16'h0000

`endif

/* sar_pin_sync.v */
`timescale 1ns/100ps
module sar_pin_sync (
    // Clock and reset.
    input  wire core_clk,
    input  wire srst,
    // Asynchronous pin and its clean level.
    input  wire pin,
    output reg  level
);

    reg stage1;
    reg stage2;
    reg stage3;

    // Three flops feed a fourth; the level follows only once stages two and three agree.
    always @(posedge core_clk) begin
        if (srst) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
            level  <= 1'b1;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end

endmodule // sar_pin_sync

/* sar_prescaler.v */
`timescale 1ns/100ps
module sar_prescaler #(
    parameter MAX_POW = 15
) (
    // Clock and reset.
    input  wire       core_clk,
    input  wire       srst,
    // Prescaler codes and selection.
    input  wire       sel_high,
    input  wire [3:0] prs_low,
    input  wire [3:0] prs_high,
    // Operating clock enable pulse.
    output reg        mck_en
);

    reg  [MAX_POW-1:0] cnt;
    wire [MAX_POW:0]   tick;
    wire [3:0]         code;

    // Code k gives a pulse every 2^k system clocks.
    assign tick[0] = 1'b1;
    genvar k;
    generate
        for (k = 1; k <= MAX_POW; k = k + 1) begin : g_tick
            assign tick[k] = &cnt[k-1:0];
        end
    endgenerate

    assign code = sel_high ? prs_high : prs_low;

    // Free-running counter and registered enable.
    always @(posedge core_clk) begin
        if (srst) begin
            cnt    <= {MAX_POW{1'b0}};
            mck_en <= 1'b0;
        end else begin
            cnt    <= cnt + {{(MAX_POW-1){1'b0}}, 1'b1};
            mck_en <= tick[code];
        end
    end

endmodule // sar_prescaler

/* sar_rx_assertions.sv */
`timescale 1ns/100ps
module sar_rx_assertions (
    // Clock, reset and unit gate.
    input wire        core_clk,
    input wire        rst,
    input wire        peripheral_clock_gate,
    // Register bus.
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // Interrupt lines.
    input wire        receive_end_irq,
    input wire        receive_error_irq
);
    // Either reset source holds the whole unit.
    wire held_off = rst || !peripheral_clock_gate;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (held_off);
    // A taken request is answered on the next cycle and only for one cycle.
    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_no_idle_ack: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest dropped without a request");
    // Read data changes only when a read is taken; upper half is always zero.
    a_read_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
        else $error("read data upper half not zero");
    // Error pulses ride on the end pulse; end pulses are more than eight cycles apart.
    a_err_with_end: assert property (receive_error_irq |-> receive_end_irq)
        else $error("error pulse without end pulse");
    a_end_spacing: assert property (receive_end_irq |=> !receive_end_irq [*8])
        else $error("end pulses too close together");
    // Reset or a gated clock leaves the outputs quiet on the next cycle.
    a_reset_quiet: assert property (disable iff (1'b0) held_off |=>
        avs_waitrequest && !receive_end_irq && !receive_error_irq && avs_readdata == 32'h0)
        else $error("outputs not cleared by reset");
endmodule // sar_rx_assertions

/* sar_tx_model.sv */
`timescale 1ns/100ps
module sar_tx_model (
    // Clock and frame command.
    input  wire        core_clk,
    input  wire        go,
    input  wire [8:0]  data,
    input  wire [3:0]  len,
    input  wire [1:0]  par,
    input  wire        lsb,
    input  wire        bad_par,
    input  wire        bad_stop,
    input  wire [15:0] bit_cyc,
    // Receive line, idling at the mark level.
    output reg         line
);
    reg [11:0] fr;
    integer    i, n;
    initial line = 1'b1;
    // Builds start, data, parity and stop bits, then shifts them out at an exact rate.
    always @(posedge core_clk) begin
        if (go) begin
            fr[0] = 1'b0;
            for (i = 0; i < len; i = i + 1) begin
                fr[i + 1] = lsb ? data[i] : data[len - 1 - i];
            end
            n = len + 1;
            if (par != 2'h0) begin
                fr[n] = bad_par ^ (par == 2'h1 ? 1'b0 :
                    (^(data & ((9'h1 << len) - 9'h1))) ^ par[0]);
                n = n + 1;
            end
            fr[n] = ~bad_stop;
            for (i = 0; i <= n; i = i + 1) begin
                line <= fr[i];
                repeat (bit_cyc) @(posedge core_clk);
            end
            line <= 1'b1;
        end
    end
endmodule // sar_tx_model

/* tb_sar_rx.sv */
`timescale 1ns/100ps
`include "sar_map.vh"
// Counts one comparison and reports a mismatch.
`define CHK(got, exp) begin n_tests = n_tests + 1; if ((got) !== (exp)) begin \
    fails = fails + 1; $display("unexpected %0t: got %h want %h", $time, got, exp); end end
module tb_sar_rx;
    // Design and partner connections.
    reg         core_clk = 1'b0;
    reg         rst = 1'b1;
    reg         peripheral_clock_gate = 1'b1;
    reg  [5:0]  avs_address = 6'h00;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, serial_in_pin, receive_end_irq, receive_error_irq;
    reg         go = 1'b0, tx_lsb = 1'b1, bad_par = 1'b0, bad_stop = 1'b0;
    reg  [8:0]  tx_d = 9'h0;
    reg  [3:0]  tx_len = 4'h8;
    reg  [1:0]  tx_par = 2'h0;
    reg  [15:0] bc = 16'h6;
    // Bench state.
    integer     fails = 0, n_tests = 0, seed = 20, cyc = 0, n_end = 0, n_err = 0;
    integer     t, k, e0, e1;
    reg  [15:0] r;
    reg  [6:0]  dv;
    reg  [3:0]  cd;
    sar_rx sar_rx_inst (.core_clk, .rst, .peripheral_clock_gate, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
        .serial_in_pin, .receive_end_irq, .receive_error_irq);
    sar_tx_model sar_tx_model_inst (.core_clk, .go, .data(tx_d), .len(tx_len), .par(tx_par),
        .lsb(tx_lsb), .bad_par, .bad_stop, .bit_cyc(bc), .line(serial_in_pin));
    // Clock, watchdog and interrupt pulse counters.
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (receive_end_irq === 1'b1) n_end <= n_end + 1;
        if (receive_error_irq === 1'b1) n_err <= n_err + 1;
        if (cyc == 30000) begin
            fails = fails + 1;
            results;
        end
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Holds one request until waitrequest is seen low, then releases it; the watchdog ends a hang.
    task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
        avs_address <= a;
        avs_writedata <= {16'h0, d};
        avs_write <= w;
        avs_read <= ~w;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        r = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    // Sends one frame, waits a bounded time for its end pulse, then idles the line.
    task automatic send(input logic [8:0] d, input logic bp, input logic bs);
        integer n;
        e0 = n_end;
        tx_d <= d;
        bad_par <= bp;
        bad_stop <= bs;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        n = 0;
        while (n_end == e0 && n < 14 * bc) begin
            @(posedge core_clk);
            n = n + 1;
        end
        repeat (3 * bc) @(posedge core_clk);
    endtask
    // Character as the receiver should keep it for a given length.
    function automatic [8:0] keep(input [8:0] d, input [3:0] n);
        keep = d & ((9'h1 << n) - 9'h1);
    endfunction
    // Main sequence: reset values, every parity and length pair, then the error paths.
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        bus(1'b0, `SAR_OFS_CONTROL, 16'h0);
        `CHK(r, 16'h0078)
        bus(1'b0, `SAR_OFS_DATA, 16'h0);
        `CHK(r[15:9], `SAR_RST_DIV)
        bus(1'b0, 6'h30, 16'h0);
        `CHK(r, 16'h0000)
        for (t = 0; t < 12; t = t + 1) begin
            k = $random(seed);
            dv = 7'd2 + {5'h0, k[1:0]};
            cd = {3'h0, k[2]};
            bc <= (16'h2 << cd) * ({9'h0, dv} + 16'h1);
            tx_lsb <= k[4];
            tx_par <= t[1:0];
            tx_len <= 4'h7 + {2'h0, t[3:2]};
            bus(1'b1, k[5] ? `SAR_OFS_OUT_EN : `SAR_OFS_OUT_LEVEL, k[15:0]);
            bus(1'b0, k[5] ? `SAR_OFS_OUT_EN : `SAR_OFS_OUT_LEVEL, 16'h0);
            `CHK(r, k[15:0])
            bus(1'b1, `SAR_OFS_MODE, {15'h0, k[3]});
            bus(1'b1, `SAR_OFS_PRESCALE, k[3] ? {8'h0, cd, k[11:8]} : {8'h0, k[11:8], cd});
            bus(1'b1, `SAR_OFS_PAIR_MODE, k[31:16]);
            bus(1'b1, `SAR_OFS_DATA, {dv, 9'h0});
            bus(1'b1, `SAR_OFS_CONTROL, {8'h0, tx_len - 4'h1, tx_lsb, tx_par, 1'b1});
            repeat (4 << cd) @(posedge core_clk);
            bus(1'b1, `SAR_OFS_START, 16'h0002);
            bus(1'b0, `SAR_OFS_ENABLE, 16'h0);
            `CHK(r[1], 1'b1)
            e1 = n_err;
            send(k[30:22], 1'b0, 1'b0);
            `CHK(n_end, e0 + 1)
            `CHK(n_err, e1)
            bus(1'b0, `SAR_OFS_DATA, 16'h0);
            `CHK(r[8:0], keep(k[30:22], tx_len))
            bus(1'b0, `SAR_OFS_STATUS, 16'h0);
            `CHK(r[6:0], 7'h00)
            bus(1'b1, `SAR_OFS_STOP, 16'h000f);
            bus(1'b0, `SAR_OFS_ENABLE, 16'h0);
            `CHK(r[1], 1'b0)
        end
        bus(1'b1, `SAR_OFS_START, 16'h0002);
        e1 = n_err;
        send(9'h0a5, 1'b1, 1'b0);
        `CHK(n_err, e1 + 1)
        bus(1'b0, `SAR_OFS_DATA, 16'h0);
        bus(1'b0, `SAR_OFS_STATUS, 16'h0);
        `CHK(r[2:0], 3'h2)
        bus(1'b1, `SAR_OFS_FLAG_CLR, r);
        bus(1'b0, `SAR_OFS_STATUS, 16'h0);
        `CHK(r[2:0], 3'h0)
        send(9'h13c, 1'b0, 1'b0);
        send(9'h0c3, 1'b0, 1'b0);
        bus(1'b0, `SAR_OFS_STATUS, 16'h0);
        `CHK(r[2:0], 3'h1)
        bus(1'b0, `SAR_OFS_DATA, 16'h0);
        `CHK(r[8:0], 9'h0c3)
        bus(1'b1, `SAR_OFS_FLAG_CLR, 16'h0007);
        send(9'h155, 1'b0, 1'b1);
        bus(1'b0, `SAR_OFS_DATA, 16'h0);
        bus(1'b0, `SAR_OFS_STATUS, 16'h0);
        `CHK(r[2:0], 3'h4)
        bus(1'b1, `SAR_OFS_FLAG_CLR, r);
        bus(1'b1, `SAR_OFS_STOP, 16'h0002);
        send(9'h0ff, 1'b0, 1'b0);
        `CHK(n_end, e0)
        bus(1'b1, `SAR_OFS_START, 16'h0002);
        send(9'h0f0, 1'b0, 1'b0);
        bus(1'b0, `SAR_OFS_DATA, 16'h0);
        `CHK(r[8:0], 9'h0f0)
        peripheral_clock_gate <= 1'b0;
        repeat (2) @(posedge core_clk);
        peripheral_clock_gate <= 1'b1;
        @(posedge core_clk);
        bus(1'b0, `SAR_OFS_CONTROL, 16'h0);
        `CHK(r, 16'h0078)
        bus(1'b0, `SAR_OFS_ENABLE, 16'h0);
        `CHK(r[1], 1'b0)
        results;
    end
endmodule // tb_sar_rx
bind sar_rx sar_rx_assertions sar_rx_assertions_inst (.core_clk, .rst, .peripheral_clock_gate,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .receive_end_irq,
    .receive_error_irq);
